// ---- rtl/uts_top.sv ----
// Ultrasonic trigger select: three selectors with AHB-Lite register access.
// Assumes all trigger sources are synchronous single-clock signals.
// Operation
// R1 - Power-up code 00 soft bit, 01 RTC
// R2 - Power-up code 10 timer A0, 11 pin
// R3 - Pulse gen: soft, acq seq, timer A2
// R4 - Software never writes pulse gen code 11
// R5 - Acq seq: soft, power seq, timer A1
// R6 - Reserved code gives no trigger
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module uts_top (
  // Clock, reset, enable.
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Trigger sources.
  input wire logic i_rtc_event,
  input wire logic i_timer_a0_compare_channel_2,
  input wire logic i_port1_pin7,
  input wire logic i_acquisition_sequencer,
  input wire logic i_timer_a2_compare_channel_1,
  input wire logic i_power_sequencer,
  input wire logic i_timer_a1_compare_channel_2,
  // Triggers to engines.
  output logic o_power_up_trig,
  output logic o_pulse_gen_trig,
  output logic o_acq_seq_trig
);
  import uts_pkg::*;

  // True when an address phase is taken at this edge.
  function automatic logic take_f(input logic sel, input logic rdy, input logic [1:0] trans);
    take_f = sel && rdy && trans[1];
  endfunction

  logic take;
  logic [5:0] sel_r, sel_nxt;
  logic [2:0] soft_r, soft_nxt;
  logic [2:0] trig_r, trig_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [31:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] mux_out;

  uts_mux_if pwr_if();
  uts_mux_if ppg_if();
  uts_mux_if acq_if();

  assign pwr_if.sel = sel_r[POS_PWR +: SEL_W];
  assign pwr_if.src = {i_port1_pin7, i_timer_a0_compare_channel_2, i_rtc_event,
                       soft_r[POS_SOFT_PWR]}; // R1 R2
  assign ppg_if.sel = sel_r[POS_PPG +: SEL_W];
  assign ppg_if.src = {1'b0, i_timer_a2_compare_channel_1, i_acquisition_sequencer,
                       soft_r[POS_SOFT_PPG]}; // R3
  assign acq_if.sel = sel_r[POS_ACQ +: SEL_W];
  assign acq_if.src = {1'b0, i_timer_a1_compare_channel_2, i_power_sequencer,
                       soft_r[POS_SOFT_ACQ]}; // R5
  assign mux_out = {acq_if.trig, ppg_if.trig, pwr_if.trig};

  uts_mux #(.HAS_RSVD(1'b0)) u_pwr (.m(pwr_if));
  uts_mux #(.HAS_RSVD(1'b1)) u_ppg (.m(ppg_if));
  uts_mux #(.HAS_RSVD(1'b1)) u_acq (.m(acq_if));

  assign take = take_f(i_hsel, i_hready, i_htrans);
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_r;
  assign o_power_up_trig = trig_r[0];
  assign o_pulse_gen_trig = trig_r[1];
  assign o_acq_seq_trig = trig_r[2];

  always_comb begin
    sel_nxt = sel_r;
    soft_nxt = 3'h0;
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = rdata_r;
    if (wr_pend_r) begin
      if (wr_addr_r == OFS_SELECT) begin
        sel_nxt = i_hwdata[5:0];
      end else if (wr_addr_r == OFS_SOFT) begin
        soft_nxt = i_hwdata[2:0];
      end
    end
    if (take) begin
      wr_pend_nxt = i_hwrite;
      wr_addr_nxt = i_haddr;
      if (!i_hwrite) begin
        unique case (i_haddr)
          OFS_SELECT: rdata_nxt = {26'h000_0000, sel_nxt};
          OFS_STATUS: rdata_nxt = {29'h0000_0000, trig_r};
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_comb begin
    trig_nxt = mux_out; // R6
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      trig_r <= 3'h0;
    end else if (i_ce) begin
      trig_r <= trig_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sel_r <= RST_SELECT[5:0];
      soft_r <= 3'h0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
    end else if (i_ce) begin
      sel_r <= sel_nxt;
      soft_r <= soft_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ppg_rsvd_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[3:2] == PPG_SEL_RSVD |=> !o_pulse_gen_trig) // R6
    else $error("pulse gen triggered on reserved code");
  acq_rsvd_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[5:4] == ACQ_SEL_RSVD |=> !o_acq_seq_trig) // R6
    else $error("acq seq triggered on reserved code");
  pwr_rtc_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[1:0] == PWR_SEL_RTC |=> o_power_up_trig == $past(i_rtc_event)) // R1
    else $error("power-up not following rtc");
  pwr_pin_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[1:0] == PWR_SEL_PIN |=> o_power_up_trig == $past(i_port1_pin7)) // R2
    else $error("power-up not following pin");
  pwr_ta0_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[1:0] == PWR_SEL_TA0
    |=> o_power_up_trig == $past(i_timer_a0_compare_channel_2)) // R2
    else $error("power-up not following timer a0");
  ppg_ta2_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[3:2] == PPG_SEL_TA2
    |=> o_pulse_gen_trig == $past(i_timer_a2_compare_channel_1)) // R3
    else $error("pulse gen not following timer a2");
  ppg_acq_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[3:2] == PPG_SEL_ACQ
    |=> o_pulse_gen_trig == $past(i_acquisition_sequencer)) // R3
    else $error("pulse gen not following acq seq");
  acq_pwr_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[5:4] == ACQ_SEL_PWR |=> o_acq_seq_trig == $past(i_power_sequencer)) // R5
    else $error("acq seq not following power seq");
  acq_ta1_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[5:4] == ACQ_SEL_TA1
    |=> o_acq_seq_trig == $past(i_timer_a1_compare_channel_2)) // R5
    else $error("acq seq not following timer a1");

  pwr_soft_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[1:0] == PWR_SEL_SOFT
    |=> o_power_up_trig == $past(soft_r[POS_SOFT_PWR])) // R1
    else $error("power-up not following soft bit");
  ppg_soft_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[3:2] == PPG_SEL_SOFT
    |=> o_pulse_gen_trig == $past(soft_r[POS_SOFT_PPG])) // R3
    else $error("pulse gen not following soft trigger");
  acq_soft_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && sel_r[5:4] == ACQ_SEL_SOFT
    |=> o_acq_seq_trig == $past(soft_r[POS_SOFT_ACQ])) // R5
    else $error("acq seq not following soft trigger");

  reset_clear_a: assert property (@(posedge i_clk)
    i_reset |=> trig_r == 3'h0 && sel_r == RST_SELECT[5:0] && o_hrdata == 32'h0000_0000)
    else $error("state not cleared by reset");
  trig_freeze_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_ce |=> trig_r == $past(trig_r)) // R6
    else $error("triggers moved while disabled");
  sel_freeze_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_ce |=> sel_r == $past(sel_r))
    else $error("select moved while disabled");
  rdata_freeze_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_ce |=> o_hrdata == $past(o_hrdata))
    else $error("read data moved while disabled");

  sel_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && wr_pend_r && wr_addr_r == OFS_SELECT
    |=> sel_r == $past(i_hwdata[5:0])) // R1
    else $error("select write lost");
  soft_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && !(wr_pend_r && wr_addr_r == OFS_SOFT)
    |=> soft_r == 3'h0) // R6
    else $error("soft trigger not self-clearing");
  pend_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && !take |=> !wr_pend_r)
    else $error("write pending without address phase");
  sel_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && take && !i_hwrite && i_haddr == OFS_SELECT
    |=> o_hrdata == {26'h000_0000, $past(sel_nxt)}) // R1
    else $error("select read wrong");
  soft_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && take && !i_hwrite && i_haddr == OFS_SOFT
    |=> o_hrdata == 32'h0000_0000)
    else $error("soft register read not zero");
  status_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_ce && take && !i_hwrite && i_haddr == OFS_STATUS
    |=> o_hrdata == {29'h0000_0000, $past(trig_r)})
    else $error("status read wrong");
  bus_okay_a: assert property (@(posedge i_clk)
    o_hreadyout && !o_hresp)
    else $error("bus response not ready and okay");
endmodule

// ---- rtl/uts_pkg.sv ----
// Package for the ultrasonic trigger select block: select codes and reset values.
// Assumes a single clock domain and 2-bit select fields.
package uts_pkg;
  localparam int SEL_W = 2;
  typedef logic [SEL_W-1:0] uts_sel_t;
  // Power-up trigger select codes.
  localparam uts_sel_t PWR_SEL_SOFT = 2'h0;
  localparam uts_sel_t PWR_SEL_RTC = 2'h1;
  localparam uts_sel_t PWR_SEL_TA0 = 2'h2;
  localparam uts_sel_t PWR_SEL_PIN = 2'h3;
  // Pulse generator trigger select codes.
  localparam uts_sel_t PPG_SEL_SOFT = 2'h0;
  localparam uts_sel_t PPG_SEL_ACQ = 2'h1;
  localparam uts_sel_t PPG_SEL_TA2 = 2'h2;
  localparam uts_sel_t PPG_SEL_RSVD = 2'h3;
  // Acquisition sequencer trigger select codes.
  localparam uts_sel_t ACQ_SEL_SOFT = 2'h0;
  localparam uts_sel_t ACQ_SEL_PWR = 2'h1;
  localparam uts_sel_t ACQ_SEL_TA1 = 2'h2;
  localparam uts_sel_t ACQ_SEL_RSVD = 2'h3;
  // Register map, byte addresses, and select register reset value.
  localparam logic [31:0] OFS_SELECT = 32'h0000_0000;
  localparam logic [31:0] OFS_SOFT = 32'h0000_0004;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
  localparam logic [31:0] RST_SELECT = 32'h0000_0000;
  // Field positions in the select register.
  localparam int POS_PWR = 0;
  localparam int POS_PPG = 2;
  localparam int POS_ACQ = 4;
  // Field positions in the soft trigger register.
  localparam int POS_SOFT_PWR = 0;
  localparam int POS_SOFT_PPG = 1;
  localparam int POS_SOFT_ACQ = 2;
endpackage

// ---- rtl/uts_mux_if.sv ----
// Interface carrying one 4-way trigger mux: select, sources and output.
// Assumes the mux is purely combinational.
`timescale 1ns/1ns
interface uts_mux_if;
  logic [1:0] sel;
  logic [3:0] src;
  logic trig;
  modport mux (input sel, input src, output trig);
  modport user (output sel, output src, input trig);
endinterface

// ---- rtl/uts_mux.sv ----
// One 4-way trigger selector with an optional reserved code.
// Assumes sources are synchronous to the block clock.
`timescale 1ns/1ns
module uts_mux #(
  parameter bit HAS_RSVD = 1'b1
) (
  uts_mux_if.mux m
);
  always_comb begin
    if (HAS_RSVD && m.sel == 2'h3) begin
      m.trig = 1'b0; // R6
    end else begin
      m.trig = m.src[m.sel]; // R6
    end
  end
endmodule

// ---- tb/uts_src_model.sv ----
// Partner model: timers, sequencers, clock events and pin that feed the selector.
// Assumes the bench requests levels; each source moves just after a rising edge.
`timescale 1ns/1ns
module uts_src_model (
  // Clock and requested levels.
  input wire logic i_clk,
  input wire logic [6:0] i_req,
  // Source levels.
  output logic [6:0] o_src
);
  initial o_src = 7'h00;
  always @(posedge i_clk) begin
    o_src <= i_req;
  end
endmodule

// ---- tb/ultrasonic_trigger_select_test.sv ----
// Bench for the trigger selector: AHB-Lite master, source model, self-checks.
// Assumes zero-wait-state slave and triggers one cycle behind their source.
`timescale 1ns/1ns
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module ultrasonic_trigger_select_test;
  import uts_pkg::*;
  logic i_clk = 0, i_reset = 1, i_hsel = 0, i_hwrite = 0, ce = 1;
  logic [31:0] i_haddr = 32'h0000_0000, i_hwdata = 32'h0000_0000, o_hrdata, rd;
  logic [1:0] i_htrans = 2'h0;
  logic [6:0] req = 7'h00, src;
  logic o_hreadyout, o_hresp, o_pw, o_pg, o_aq;
  int fail_count = 0, n_checks = 0, cyc = 0;
  uts_src_model uts_src_model_i (.i_clk(i_clk), .i_req(req), .o_src(src));
  uts_top uts_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_rtc_event(src[0]),
    .i_timer_a0_compare_channel_2(src[1]), .i_port1_pin7(src[2]),
    .i_acquisition_sequencer(src[3]), .i_timer_a2_compare_channel_1(src[4]),
    .i_power_sequencer(src[5]), .i_timer_a1_compare_channel_2(src[6]),
    .o_power_up_trig(o_pw), .o_pulse_gen_trig(o_pg), .o_acq_seq_trig(o_aq));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_hwrite <= w;
    i_htrans <= 2'h2;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
    i_hsel <= 1'b0;
  endtask
  function automatic logic [2:0] exp_f(input logic [5:0] v, input logic [6:0] s);
    logic [1:0] p;
    logic [1:0] g;
    logic [1:0] q;
    p = v[POS_PWR +: 2];
    g = v[POS_PPG +: 2];
    q = v[POS_ACQ +: 2];
    exp_f[0] = (p == 2'h1) ? s[0] : (p == 2'h2) ? s[1] : (p == 2'h3) ? s[2] : 1'b0;
    exp_f[1] = (g == 2'h1) ? s[3] : (g == 2'h2) ? s[4] : 1'b0;
    exp_f[2] = (q == 2'h1) ? s[5] : (q == 2'h2) ? s[6] : 1'b0;
  endfunction
  // Each code in the power-up and acq seq fields, codes 0 to 2 in the pulse gen field; each source alone; only the selected one fires.
  task automatic route_test;
    logic [31:0] v;
    for (int c = 0; c < 4; c++) begin
      v = 32'(c) | (32'((c == 3) ? 0 : c) << POS_PPG) | (32'(c) << POS_ACQ);
      bus(1'b1, OFS_SELECT, v);
      bus(1'b0, OFS_SELECT, 32'h0000_0000);
      `CHK("select", v, rd)
      for (int s = 0; s < 8; s++) begin
        @(posedge i_clk);
        req <= (s < 7) ? 7'(1 << s) : 7'h00;
        repeat (3) @(posedge i_clk);
        #1;
        `CHK("trig", exp_f(v[5:0], req), {o_aq, o_pg, o_pw})
      end
    end
  endtask
  // Soft bits pulse each trigger once while every other source is high.
  task automatic soft_test;
    bus(1'b1, OFS_SELECT, 32'h0000_0000);
    @(posedge i_clk);
    req <= 7'h7f;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("soft idle", 3'h0, {o_aq, o_pg, o_pw})
    bus(1'b1, OFS_SOFT, 32'h0000_0007);
    @(posedge i_clk);
    #1;
    `CHK("soft pulse", 3'h7, {o_aq, o_pg, o_pw})
    @(posedge i_clk);
    #1;
    `CHK("soft clear", 3'h0, {o_aq, o_pg, o_pw})
    bus(1'b0, OFS_SOFT, 32'h0000_0000);
    `CHK("soft read", 32'h0000_0000, rd)
    req <= 7'h00;
  endtask
  // Pin route, status read, then freeze with the clock enable low.
  task automatic ce_test;
    bus(1'b1, OFS_SELECT, 32'(PWR_SEL_PIN));
    @(posedge i_clk);
    req <= 7'h04;
    repeat (3) @(posedge i_clk);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK("status", 32'h0000_0001, rd)
    ce <= 1'b0;
    req <= 7'h00;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("frozen", 1'b1, o_pw)
    @(posedge i_clk);
    ce <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("resumed", 1'b0, o_pw)
  endtask
  task automatic reset_test;
    bus(1'b0, OFS_SELECT, 32'h0000_0000);
    `CHK("select reset", RST_SELECT, rd)
    `CHK("resp", 1'b0, o_hresp)
    `CHK("ready", 1'b1, o_hreadyout)
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    reset_test();
    route_test();
    soft_test();
    ce_test();
    give_verdict();
  end
endmodule
